// file: hdl/ats_pkg.sv
package ats_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] TRIG_SEL_OFFSET  = 12'h014;
  localparam logic [11:0] SWTRIG_OFFSET    = 12'h028;
  localparam logic [31:0] TRIG_SEL_RESET   = 32'h00000000;
  localparam int          SEQ1_CODE_LSB    = 4;
  localparam int          SEQ0_CODE_LSB    = 0;
  localparam int          CODE_WIDTH       = 4;
  localparam int          SEQ_COUNT        = 2;
  localparam logic [31:0] UNMAPPED_READ    = 32'h00000000;

  // ****************************************************************
  // Trigger source codes
  // ****************************************************************
  localparam logic [3:0] CODE_SOFTWARE   = 4'h0;
  localparam logic [3:0] CODE_COMPARATOR = 4'h1;
  localparam logic [3:0] CODE_EXTERNAL   = 4'h4;
  localparam logic [3:0] CODE_TIMER      = 4'h5;
  localparam logic [3:0] CODE_PWM0       = 4'h6;
  localparam logic [3:0] CODE_PWM1       = 4'h7;
  localparam logic [3:0] CODE_PWM2       = 4'h8;
  localparam logic [3:0] CODE_ALWAYS     = 4'hF;

  // ****************************************************************
  // Trigger event bundle
  // ****************************************************************
  typedef struct packed {
    logic comparator;
    logic external;
    logic timer;
    logic pwm0;
    logic pwm1;
    logic pwm2;
  } ats_events_t;

  typedef enum logic [1:0] {
    ATS_IDLE   = 2'b01,
    ATS_ACCESS = 2'b10
  } ats_state_t;

endpackage

// file: hdl/ats_trigger_select.sv
`timescale 1ns/10ps

// Contract
// - Bits 7:4 are a read/write field, reset to zero, for sequencer 1.
// - Bits 3:0 are a read/write field, reset to zero, for sequencer 0.
// - Code 0x0 is software, 0x1 comparator 0 and 0x4 the external pin.
// - Code 0xF samples continuously; 0x2, 0x3 and 0x9 to 0xE are reserved.
// - Code 0x5 selects the timer, which must enable its own trigger.
// - Code 0x6 selects PWM module 0, which sets its own trigger conditions.
// - Code 0x7 selects PWM module 1, which sets its own trigger conditions.
// - Code 0x8 selects PWM module 2, which sets its own trigger conditions.
module ats_trigger_select
  import ats_pkg::*;
(
  input  wire logic        core_clk,      // System clock
  input  wire logic        sys_rst,       // Synchronous reset
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction
  input  wire logic [11:0] paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error
  input  ats_events_t      trigEvents,    // Source event pulses
  output logic      [1:0]  seqTrigger     // Start pulse per sequencer
);

  // ****************************************************************
  // Bus slave state
  // ****************************************************************
  ats_state_t       state;
  ats_state_t       next_state;
  logic      [3:0]  seq0Code;
  logic      [3:0]  seq1Code;
  logic      [3:0]  next_seq0Code;
  logic      [3:0]  next_seq1Code;
  logic      [1:0]  swPend;
  logic      [1:0]  next_swPend;
  logic      [31:0] next_prdata;
  logic             next_pslverr;
  logic      [1:0]  next_seqTrigger;
  logic             mapped;
  logic             wrTake;
  logic             rdTake;

  // Select one event from a code
  function automatic logic pick(input logic [3:0] code,
                                input ats_events_t ev,
                                input logic swReq);
    case (code)
      CODE_SOFTWARE:   pick = swReq;
      CODE_COMPARATOR: pick = ev.comparator;
      CODE_EXTERNAL:   pick = ev.external;
      CODE_TIMER:      pick = ev.timer;
      CODE_PWM0:       pick = ev.pwm0;
      CODE_PWM1:       pick = ev.pwm1;
      CODE_PWM2:       pick = ev.pwm2;
      CODE_ALWAYS:     pick = 1'b1;
      default:         pick = 1'b0;
    endcase
  endfunction

  assign mapped = (paddr == TRIG_SEL_OFFSET) || (paddr == SWTRIG_OFFSET);
  assign pready = (state == ATS_ACCESS);
  assign wrTake = psel && penable && pready && pwrite;
  assign rdTake = psel && !penable && !pwrite;

  // ****************************************************************
  // Next values
  // ****************************************************************
  always_comb
  begin
    next_state      = state;
    next_seq0Code   = seq0Code;
    next_seq1Code   = seq1Code;
    next_swPend     = 2'h0;
    next_prdata     = prdata;
    next_pslverr    = 1'b0;
    case (state)
      ATS_IDLE:
      begin
        if (psel && !penable)
        begin
          next_state   = ATS_ACCESS;
          next_pslverr = !mapped;
          if (rdTake)
          begin
            if (paddr == TRIG_SEL_OFFSET)
              next_prdata = {24'h000000, seq1Code, seq0Code};
            else
              next_prdata = UNMAPPED_READ;
          end
        end
      end
      ATS_ACCESS:
      begin
        next_state = ATS_IDLE;
        if (wrTake && paddr == TRIG_SEL_OFFSET)
        begin
          next_seq1Code = pwdata[SEQ1_CODE_LSB +: CODE_WIDTH];
          next_seq0Code = pwdata[SEQ0_CODE_LSB +: CODE_WIDTH];
        end
        if (wrTake && paddr == SWTRIG_OFFSET)
          next_swPend = pwdata[1:0];
      end
      default:
        next_state = ATS_IDLE;
    endcase
    next_seqTrigger[0] = pick(seq0Code, trigEvents, swPend[0]);
    next_seqTrigger[1] = pick(seq1Code, trigEvents, swPend[1]);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state      <= ATS_IDLE;
      seq0Code   <= TRIG_SEL_RESET[3:0];
      seq1Code   <= TRIG_SEL_RESET[7:4];
      swPend     <= 2'h0;
      prdata     <= 32'h00000000;
      pslverr    <= 1'b0;
      seqTrigger <= 2'h0;
    end
    else
    begin
      state      <= next_state;
      seq0Code   <= next_seq0Code;
      seq1Code   <= next_seq1Code;
      swPend     <= next_swPend;
      prdata     <= next_prdata;
      pslverr    <= next_pslverr;
      seqTrigger <= next_seqTrigger;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_seq1_write;
    @(posedge core_clk) disable iff (sys_rst)
    (wrTake && paddr == TRIG_SEL_OFFSET)
      |=> (seq1Code == $past(pwdata[7:4]));
  endproperty
  a_seq1_write: assert property (p_seq1_write)
    else $error("seq1 code not written");

  property p_seq0_write;
    @(posedge core_clk) disable iff (sys_rst)
    (wrTake && paddr == TRIG_SEL_OFFSET)
      |=> (seq0Code == $past(pwdata[3:0]));
  endproperty
  a_seq0_write: assert property (p_seq0_write)
    else $error("seq0 code not written");

  property p_ext_pick;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_EXTERNAL && $stable(seq0Code))
      |=> (seqTrigger[0] == $past(trigEvents.external));
  endproperty
  a_ext_pick: assert property (p_ext_pick)
    else $error("external pick wrong");

  property p_always;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_ALWAYS)[*2] |-> seqTrigger[1];
  endproperty
  a_always: assert property (p_always)
    else $error("continuous trigger missing");

  property p_timer;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_TIMER && trigEvents.timer) |=> seqTrigger[0];
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer trigger lost");

  property p_pwm0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_PWM0) |=> (seqTrigger[1] == $past(trigEvents.pwm0));
  endproperty
  a_pwm0: assert property (p_pwm0)
    else $error("pwm0 pick wrong");

  property p_pwm1;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_PWM1) |=> (seqTrigger[0] == $past(trigEvents.pwm1));
  endproperty
  a_pwm1: assert property (p_pwm1)
    else $error("pwm1 pick wrong");

  property p_pwm2;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_PWM2) |=> (seqTrigger[1] == $past(trigEvents.pwm2));
  endproperty
  a_pwm2: assert property (p_pwm2)
    else $error("pwm2 pick wrong");

  property p_reserved;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code inside {4'h2, 4'h3, [4'h9:4'hE]}) |=> !seqTrigger[0];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code triggered");

  property p_seq1_reserved;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code inside {4'h2, 4'h3, [4'h9:4'hE]}) |=> !seqTrigger[1];
  endproperty
  a_seq1_reserved: assert property (p_seq1_reserved)
    else $error("reserved code triggered sequencer 1");

  property p_sw_seq0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_SOFTWARE)
      |=> (seqTrigger[0] == $past(swPend[0]));
  endproperty
  a_sw_seq0: assert property (p_sw_seq0)
    else $error("software pick wrong on sequencer 0");

  property p_sw_seq1;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_SOFTWARE)
      |=> (seqTrigger[1] == $past(swPend[1]));
  endproperty
  a_sw_seq1: assert property (p_sw_seq1)
    else $error("software pick wrong on sequencer 1");

  property p_comp_seq0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_COMPARATOR)
      |=> (seqTrigger[0] == $past(trigEvents.comparator));
  endproperty
  a_comp_seq0: assert property (p_comp_seq0)
    else $error("comparator pick wrong");

  property p_ext_seq1;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_EXTERNAL)
      |=> (seqTrigger[1] == $past(trigEvents.external));
  endproperty
  a_ext_seq1: assert property (p_ext_seq1)
    else $error("external pick wrong on sequencer 1");

  property p_always_seq0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_ALWAYS) |=> seqTrigger[0];
  endproperty
  a_always_seq0: assert property (p_always_seq0)
    else $error("continuous trigger missing on sequencer 0");

  property p_timer_seq1;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_TIMER)
      |=> (seqTrigger[1] == $past(trigEvents.timer));
  endproperty
  a_timer_seq1: assert property (p_timer_seq1)
    else $error("timer pick wrong on sequencer 1");

  property p_pwm0_seq0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_PWM0)
      |=> (seqTrigger[0] == $past(trigEvents.pwm0));
  endproperty
  a_pwm0_seq0: assert property (p_pwm0_seq0)
    else $error("pwm0 pick wrong on sequencer 0");

  property p_pwm1_seq1;
    @(posedge core_clk) disable iff (sys_rst)
    (seq1Code == CODE_PWM1)
      |=> (seqTrigger[1] == $past(trigEvents.pwm1));
  endproperty
  a_pwm1_seq1: assert property (p_pwm1_seq1)
    else $error("pwm1 pick wrong on sequencer 1");

  property p_pwm2_seq0;
    @(posedge core_clk) disable iff (sys_rst)
    (seq0Code == CODE_PWM2)
      |=> (seqTrigger[0] == $past(trigEvents.pwm2));
  endproperty
  a_pwm2_seq0: assert property (p_pwm2_seq0)
    else $error("pwm2 pick wrong on sequencer 0");

  property p_codes_hold;
    @(posedge core_clk) disable iff (sys_rst)
    !(wrTake && paddr == TRIG_SEL_OFFSET)
      |=> ($stable(seq0Code) && $stable(seq1Code));
  endproperty
  a_codes_hold: assert property (p_codes_hold)
    else $error("codes changed without a write");

  property p_reset_values;
    @(posedge core_clk)
    sys_rst
      |=> (seq0Code == TRIG_SEL_RESET[3:0]) &&
          (seq1Code == TRIG_SEL_RESET[7:4]) &&
          (seqTrigger == 2'h0);
  endproperty
  a_reset_values: assert property (p_reset_values)
    else $error("reset values wrong");

  property p_read_data;
    @(posedge core_clk) disable iff (sys_rst)
    (state == ATS_IDLE && rdTake && paddr == TRIG_SEL_OFFSET)
      |=> (prdata == {24'h000000, $past(seq1Code), $past(seq0Code)});
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data wrong");

  property p_unmapped;
    @(posedge core_clk) disable iff (sys_rst)
    (state == ATS_IDLE && psel && !penable && !mapped)
      |=> (pready && pslverr);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");

  property p_ready_once;
    @(posedge core_clk) disable iff (sys_rst)
    pready |=> !pready;
  endproperty
  a_ready_once: assert property (p_ready_once)
    else $error("ready held too long");

endmodule // ats_trigger_select

// file: sim/ats_trigger_sources.sv
`timescale 1ns/10ps
module ats_trigger_sources
  import ats_pkg::*;
(
  input  wire logic [5:0] fire,        // Requested source pulses
  input  wire logic       timerOutEn,  // Timer output trigger enable
  output ats_events_t     trigEvents   // Events toward the selector
);
  // PWM units pass their configured pulse straight through
  always_comb
  begin
    trigEvents = ats_events_t'(fire);
    trigEvents.timer = fire[3] & timerOutEn;
  end
endmodule // ats_trigger_sources

// file: sim/tb_adc_trigger_source_select.sv
`timescale 1ns/10ps
module tb_adc_trigger_source_select
  import ats_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        sys_rst, psel, penable, pwrite, tEn, er, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r, seed = 32'h46B6;
  logic [5:0]  fire, ev;
  logic [3:0]  c0, c1;
  logic [1:0]  seqTrigger;
  ats_events_t trigEvents;
  int          failures = 0, compares = 0, n0, n1;

  always #4 core_clk = ~core_clk;

  ats_trigger_select u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigEvents(trigEvents), .seqTrigger(seqTrigger));
  ats_trigger_sources u_src (.fire(fire), .timerOutEn(tEn),
    .trigEvents(trigEvents));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic hit(logic [3:0] c, logic [5:0] e, logic en);
    case (c)
      CODE_COMPARATOR: hit = e[5];
      CODE_EXTERNAL:   hit = e[4];
      CODE_TIMER:      hit = e[3] & en;
      CODE_PWM0:       hit = e[2];
      CODE_PWM1:       hit = e[1];
      CODE_PWM2:       hit = e[0];
      CODE_ALWAYS:     hit = 1'b1;
      default:         hit = 1'b0;
    endcase
  endfunction

  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task complete_run();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #200000;
    failures++;
    complete_run();
  end

  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata, fire, tEn} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, TRIG_SEL_OFFSET, 32'h0);
    check("reset", rd, TRIG_SEL_RESET);
    for (int i = 0; i < 48; i++)
    begin
      r = rnd();
      r[14] = r[14] | (i < 16);
      c0 = i[3:0];
      c1 = (i < 16) ? 4'hF - i[3:0] : r[7:4];
      ev = (i < 16) ? 6'h3F : r[13:8];
      apb(1'b1, TRIG_SEL_OFFSET, {r[31:8], c1, c0});
      apb(1'b0, TRIG_SEL_OFFSET, 32'h0);
      check("codes", rd, {24'h0, c1, c0});
      check("slverr", er, 1'b0);
      @(posedge core_clk);
      fire <= ev;
      tEn <= r[14];
      @(posedge core_clk);
      fire <= 6'h00;
      #1 check("seq0", seqTrigger[0], hit(c0, ev, r[14]));
      check("seq1", seqTrigger[1], hit(c1, ev, r[14]));
      @(posedge core_clk) #1;
      check("idle", seqTrigger, {hit(c1, 0, 0), hit(c0, 0, 0)});
      apb(1'b1, SWTRIG_OFFSET, {30'h0, r[16:15]});
      {n0, n1} = '0;
      repeat (5) @(posedge core_clk) #1 {n0, n1} = {n0 + seqTrigger[0],
                                                     n1 + seqTrigger[1]};
      check("sw0", n0, c0 == 4'hF ? 5 : (c0 == 4'h0 && r[15]));
      check("sw1", n1, c1 == 4'hF ? 5 : (c1 == 4'h0 && r[16]));
    end
    apb(1'b1, 12'h100, 32'h0000_00FF);
    check("unmapped", er, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    check("unmappedRd", rd, 32'h0);
    check("unmappedErr", er, 1'b1);
    apb(1'b0, SWTRIG_OFFSET, 32'h0);
    check("swRead", rd, 32'h0);
    check("swErr", er, 1'b0);
    apb(1'b0, TRIG_SEL_OFFSET, 32'h0);
    check("kept", rd, {24'h0, c1, c0});
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    check("rstTrig", seqTrigger, 2'h0);
    apb(1'b0, TRIG_SEL_OFFSET, 32'h0);
    check("rstCodes", rd, TRIG_SEL_RESET);
    complete_run();
  end
endmodule // tb_adc_trigger_source_select
